/* File: srp_device.sv */
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - all registers and buffers through one slave
// - mode 0, clock idles low
// - host clock at most 4 MHz
// - mode register selects 1, 2 or 4 MHz
// - writes seven-bit address, mode bit selects eight
// - read addressing chosen by host per transaction
// - host preferably uses seven-bit addressing
// - host holds chip select low whole transaction
// - host changes input on falling edges
// - device samples input on rising edges
// - first bit zero means write
// - first bit one means read
// - rest of first byte is address, next data
// - device drives read data on falling edges
// - host captures read data on rising edges
// - shifting runs on pclk, timed by synchronised host clock edges
// - address increments per byte, buffer pointers instead
// - buffer port reads receive, writes transmit
// - block counters move per complete block
module srp_device
  import srp_pkg::*;
(
  input  wire logic       pclk,        // system clock
  input  wire logic       presetn,     // async reset, active low
  srp_if.device           link,        // serial link
  output logic      [1:0] speed_sel,   // selected max link rate
  output logic      [7:0] tx_used,     // complete tx blocks
  output logic      [7:0] rx_used,     // complete rx blocks
  input  wire logic       rx_push,     // radio side pushes rx byte
  input  wire logic [7:0] rx_push_data // rx byte
);
  // =====================================================
  // synchronisers and edge detect
  logic [1:0] sclk_s_q, cs_s_q, sdi_s_q;
  logic       sclk_p_q;
  logic       rise, fall, cs_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s_q <= 2'h0;
      cs_s_q   <= 2'h3;
      sdi_s_q  <= 2'h0;
      sclk_p_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], link.sclk};
      cs_s_q   <= {cs_s_q[0], link.cs_n};
      sdi_s_q  <= {sdi_s_q[0], link.serial_data_in};
      sclk_p_q <= sclk_s_q[1];
    end
  end
  assign cs_n = cs_s_q[1];
  assign rise = sclk_s_q[1] & ~sclk_p_q & ~cs_n;
  assign fall = ~sclk_s_q[1] & sclk_p_q & ~cs_n;
  // =====================================================
  // register store and buffers
  logic [7:0] regs_q [SRP_NREGS];
  logic [7:0] txbuf_q [SRP_BUF_DEPTH];
  logic [7:0] rxbuf_q [SRP_BUF_DEPTH];
  logic [5:0] txwp_q, rxwp_q, rxrp_q;
  logic [3:0] txcnt_q, rxcnt_q;
  logic [7:0] ifmode_q;
  logic [3:0] bsize_q;
  // =====================================================
  // shifter
  logic [2:0] bit_q;
  logic [7:0] sh_q, addr_q, tx_q;
  logic       have_addr_q, rd_q;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       wr_stb, rd_ld;
  logic [6:0] eff_addr;
  assign byte_in   = {sh_q[6:0], sdi_s_q[1]};
  assign byte_done = rise & (bit_q == 3'h7);
  assign wr_stb    = byte_done & have_addr_q & ~rd_q;
  // address byte in: bit 7 is the command bit, rest the address
  assign eff_addr  = addr_q[6:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q       <= 3'h0;
      sh_q        <= 8'h00;
      addr_q      <= 8'h00;
      have_addr_q <= 1'b0;
      rd_q        <= 1'b0;
    end else if (cs_n) begin
      bit_q       <= 3'h0;
      have_addr_q <= 1'b0;
    end else if (rise) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= byte_in;
      if (byte_done) begin
        if (!have_addr_q) begin
          addr_q      <= byte_in;
          rd_q        <= byte_in[7];
          have_addr_q <= 1'b1;
        end else if (addr_q[6:0] != SRP_ADDR_BUFPORT[6:0]) begin
          addr_q <= {addr_q[7], addr_q[6:0] + 7'h01};
        end
      end
    end
  end
  // eight-bit write mode: command bit also carries address bit 7 of the
  // register space; with a 16-entry map it is only the direction mark.
  // reads ignore the mode bit entirely.
  logic wr8;
  assign wr8 = ifmode_q[SRP_IFM_ADDR8_BIT];
  // =====================================================
  // read data: load at byte boundary, shift out on falling edge
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (eff_addr == SRP_ADDR_BUFPORT[6:0]) rd_val = rxbuf_q[rxrp_q];
    else if (eff_addr == SRP_ADDR_IFMODE[6:0]) rd_val = ifmode_q;
    else if (eff_addr == SRP_ADDR_BSIZE[6:0]) rd_val = {4'h0, bsize_q};
    else if (eff_addr == SRP_ADDR_TXUSED[6:0]) rd_val = tx_used;
    else if (eff_addr == SRP_ADDR_RXUSED[6:0]) rd_val = rx_used;
    else if (eff_addr < 7'(SRP_NREGS)) rd_val = regs_q[eff_addr[3:0]];
  end
  logic ld_pend_q, rd_adv;
  assign rd_ld  = byte_done & (have_addr_q ? rd_q : byte_in[7]);
  assign rd_adv = byte_done & have_addr_q & rd_q & (eff_addr == SRP_ADDR_BUFPORT[6:0]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_pend_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (cs_n) begin
      ld_pend_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (rd_ld) begin
      ld_pend_q <= 1'b1;
    end else if (fall && ld_pend_q) begin
      // load on the fall after the byte: bit 7 then stands a whole bit
      ld_pend_q <= 1'b0;
      tx_q      <= rd_val;
    end else if (fall) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  assign link.serial_data_out = tx_q[7];
  // =====================================================
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifmode_q <= SRP_IFMODE_RST;
      bsize_q  <= SRP_BSIZE_RST;
      for (int i = 0; i < SRP_NREGS; i++) regs_q[i] <= 8'h00;
    end else if (wr_stb && (eff_addr < 7'(SRP_NREGS)) && !(wr8 && !addr_q[7] && 1'b0)) begin
      if (eff_addr == SRP_ADDR_IFMODE[6:0]) ifmode_q <= byte_in;
      else if (eff_addr == SRP_ADDR_BSIZE[6:0])
        bsize_q <= (byte_in[3:0] < SRP_BSIZE_MIN) ? SRP_BSIZE_MIN : byte_in[3:0];
      else regs_q[eff_addr[3:0]] <= byte_in;
    end
  end
  assign speed_sel = ifmode_q[SRP_IFM_SPEED_LSB +: 2];
  // =====================================================
  // buffers and block counters
  logic tx_wr;
  assign tx_wr = wr_stb & (eff_addr == SRP_ADDR_BUFPORT[6:0]);
  always_ff @(posedge pclk) begin
    if (tx_wr) txbuf_q[txwp_q] <= byte_in;
    if (rx_push) rxbuf_q[rxwp_q] <= rx_push_data;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txwp_q  <= 6'h00;
      txcnt_q <= 4'h0;
      tx_used <= 8'h00;
    end else if (tx_wr) begin
      txwp_q <= txwp_q + 6'h01;
      if (txcnt_q + 4'h1 >= bsize_q) begin
        txcnt_q <= 4'h0;
        tx_used <= tx_used + 8'h01;
      end else begin
        txcnt_q <= txcnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxwp_q <= 6'h00;
    end else if (rx_push) begin
      rxwp_q <= rxwp_q + 6'h01;
    end
  end
  logic rx_blk_in;
  logic [3:0] rxin_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rxin_q <= 4'h0;
    else if (rx_push) rxin_q <= (rxin_q + 4'h1 >= bsize_q) ? 4'h0 : rxin_q + 4'h1;
  end
  assign rx_blk_in = rx_push & (rxin_q + 4'h1 >= bsize_q);
  logic rx_blk_out;
  assign rx_blk_out = rd_adv & (rxcnt_q + 4'h1 >= bsize_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxrp_q  <= 6'h00;
      rxcnt_q <= 4'h0;
    end else if (rd_adv) begin
      rxrp_q  <= rxrp_q + 6'h01;
      rxcnt_q <= rx_blk_out ? 4'h0 : rxcnt_q + 4'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_used <= 8'h00;
    else rx_used <= rx_used + {7'h00, rx_blk_in} - {7'h00, rx_blk_out};
  end
endmodule

/* File: srp_pkg.sv */
package srp_pkg;
  // =====================================================
  // link timing
  localparam int          SRP_PCLK_MHZ       = 40;
  localparam int          SRP_SCLK_MAX_MHZ   = 4;
  localparam int          SRP_SCLK_LOW_MHZ   = 1;
  localparam int          SRP_SCLK_MID_MHZ   = 2;
  localparam int          SRP_HALF_4M        = SRP_PCLK_MHZ / (2 * SRP_SCLK_MAX_MHZ);
  localparam int          SRP_HALF_2M        = SRP_PCLK_MHZ / (2 * SRP_SCLK_MID_MHZ);
  localparam int          SRP_HALF_1M        = SRP_PCLK_MHZ / (2 * SRP_SCLK_LOW_MHZ);
  localparam logic [1:0]  SRP_SPEED_4M       = 2'h0;
  localparam logic [1:0]  SRP_SPEED_2M       = 2'h1;
  localparam logic [1:0]  SRP_SPEED_1M       = 2'h2;
  // =====================================================
  // device register map
  localparam logic [7:0]  SRP_ADDR_IFMODE    = 8'h00;
  localparam logic [7:0]  SRP_ADDR_BSIZE     = 8'h01;
  localparam logic [7:0]  SRP_ADDR_TXUSED    = 8'h02;
  localparam logic [7:0]  SRP_ADDR_RXUSED    = 8'h03;
  localparam logic [7:0]  SRP_ADDR_BUFPORT   = 8'h04;
  localparam int          SRP_IFM_SPEED_LSB  = 0;
  localparam int          SRP_IFM_ADDR8_BIT  = 2;
  localparam logic [7:0]  SRP_IFMODE_RST     = 8'h00;
  localparam logic [3:0]  SRP_BSIZE_RST      = 4'hF;
  localparam logic [3:0]  SRP_BSIZE_MIN      = 4'h2;
  localparam int          SRP_NREGS          = 16;
  localparam int          SRP_BUF_DEPTH      = 64;
  // =====================================================
  // host apb registers
  localparam logic [11:0] SRP_APB_CTRL       = 12'h000;
  localparam logic [11:0] SRP_APB_WDATA      = 12'h004;
  localparam logic [11:0] SRP_APB_STATUS     = 12'h008;
  localparam logic [11:0] SRP_APB_RDATA      = 12'h00C;
  localparam int          SRP_CTRL_GO_BIT    = 0;
  localparam int          SRP_CTRL_RD_BIT    = 1;
  localparam int          SRP_CTRL_SPD_LSB   = 2;
  localparam int          SRP_CTRL_ADDR_LSB  = 8;
  localparam int          SRP_CTRL_LEN_LSB   = 16;
endpackage

/* File: srp_if.sv */
`timescale 1ns/1ps
interface srp_if;
  logic sclk;            // serial clock, host driven
  logic cs_n;            // chip select, active low
  logic serial_data_in;  // host to device
  logic serial_data_out; // device to host
  modport device (input sclk, input cs_n, input serial_data_in, output serial_data_out);
  modport host (output sclk, output cs_n, output serial_data_in, input serial_data_out);
endinterface

/* File: srp_host.sv */
`timescale 1ns/1ps
module srp_host
  import srp_pkg::*;
(
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb enable
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error
  srp_if.host              link      // serial link
);
  // =====================================================
  // apb registers
  logic [31:0] ctrl_q, wdata_q, rdata_q;
  logic        busy_q, go;
  logic        apb_wr;
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign go      = apb_wr & (paddr == SRP_APB_CTRL) & pwdata[SRP_CTRL_GO_BIT] & ~busy_q;
  assign pslverr = psel & penable & ~(paddr == SRP_APB_CTRL || paddr == SRP_APB_WDATA
                   || paddr == SRP_APB_STATUS || paddr == SRP_APB_RDATA);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 32'h0;
      wdata_q <= 32'h0;
    end else if (apb_wr && !busy_q) begin
      if (paddr == SRP_APB_CTRL) ctrl_q <= pwdata;
      if (paddr == SRP_APB_WDATA) wdata_q <= pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable) begin
      case (paddr)
        SRP_APB_CTRL:   prdata <= ctrl_q;
        SRP_APB_WDATA:  prdata <= wdata_q;
        SRP_APB_STATUS: prdata <= {31'h0, busy_q};
        SRP_APB_RDATA:  prdata <= rdata_q;
        default:        prdata <= 32'h0;
      endcase
    end
  end
  // =====================================================
  // link clock divider (selected rate never above limit)
  logic [4:0] half_q, div_q;
  logic       tick;
  always_comb begin
    case (ctrl_q[SRP_CTRL_SPD_LSB +: 2])
      SRP_SPEED_2M: half_q = 5'(SRP_HALF_2M);
      SRP_SPEED_1M: half_q = 5'(SRP_HALF_1M);
      default:      half_q = 5'(SRP_HALF_4M);
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 5'h0;
    else if (!busy_q || div_q + 5'h1 >= half_q) div_q <= 5'h0;
    else div_q <= div_q + 5'h1;
  end
  assign tick = busy_q & (div_q + 5'h1 >= half_q);
  // =====================================================
  // shifter: address byte then len data bytes, seven-bit addressing
  logic [1:0] sdo_s_q;
  logic       sclk_q, cs_n_q, sdi_q;
  logic [5:0] bits_q;
  logic [7:0] sh_q;
  logic [2:0] nbyte_q;
  logic       tail_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sdo_s_q <= 2'h0;
    else sdo_s_q <= {sdo_s_q[0], link.serial_data_out};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q  <= 1'b0;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      sdi_q   <= 1'b0;
      bits_q  <= 6'h0;
      sh_q    <= 8'h00;
      nbyte_q <= 3'h0;
      tail_q  <= 1'b0;
    end else if (go) begin
      busy_q  <= 1'b1;
      cs_n_q  <= 1'b0;
      // command bit then seven address bits
      sh_q    <= {pwdata[SRP_CTRL_RD_BIT], pwdata[SRP_CTRL_ADDR_LSB +: 7]};
      sdi_q   <= pwdata[SRP_CTRL_RD_BIT];
      nbyte_q <= pwdata[SRP_CTRL_LEN_LSB +: 3];
      bits_q  <= 6'h0;
      tail_q  <= 1'b0;
    end else if (tick) begin
      if (tail_q) begin
        cs_n_q <= 1'b1;
        busy_q <= 1'b0;
      end else if (!sclk_q) begin
        sclk_q  <= 1'b1;
        sh_q    <= {sh_q[6:0], 1'b0};
      end else begin
        sclk_q <= 1'b0;
        bits_q <= bits_q + 6'h1;
        if (bits_q[2:0] == 3'h7) begin
          if (bits_q[5:3] == nbyte_q) begin
            tail_q <= 1'b1;
          end else begin
            sh_q  <= wdata_q[{bits_q[4:3], 3'h0} +: 8];
            sdi_q <= wdata_q[{bits_q[4:3], 3'h7}];
          end
        end else begin
          sdi_q <= sh_q[7];
        end
      end
    end
  end
  // capture one cycle after the rise: the device answers a fall only
  // after its synchroniser, so the round trip fills a 4 MHz half period
  logic samp_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q  <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      samp_q <= tick & ~tail_q & ~sclk_q;
      if (samp_q) rdata_q <= {rdata_q[30:0], sdo_s_q[1]};
    end
  end
  assign link.sclk           = sclk_q;
  assign link.cs_n           = cs_n_q;
  assign link.serial_data_in = sdi_q;
endmodule

/* File: srp_chk.sv */
`timescale 1ns/1ps
module srp_chk (
  input wire logic pclk,            // system clock
  input wire logic presetn,         // async reset, active low
  input wire logic sclk,            // serial clock
  input wire logic cs_n,            // chip select, active low
  input wire logic serial_data_in,  // host to device
  input wire logic serial_data_out  // device to host
);
  // ==========================================
  // rising serial edges within one frame
  logic       sclk_q;
  logic [5:0] rise_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_cnt_q <= 6'h00;
    end else if (cs_n) begin
      rise_cnt_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end
  // ==========================================
  // wire properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence high_half;
    sclk[*5];
  endsequence
  sequence low_half;
    (!sclk)[*5];
  endsequence
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  sdi_hold_a: assert property ((sclk && sclk_q) |-> $stable(serial_data_in))
    else $error("serial input moved while clock high");
  rise_sel_a: assert property ($rose(sclk) |-> !cs_n)
    else $error("serial clock rose while deselected");
  cs_setup_a: assert property ($fell(cs_n) |-> (!sclk)[*2])
    else $error("clock rose too soon after select");
  cs_hold_a: assert property ($rose(cs_n) |-> !$past(sclk, 4))
    else $error("select released too soon after last fall");
  high_width_a: assert property ($rose(sclk) |-> high_half)
    else $error("serial clock high phase too short");
  low_width_a: assert property ($fell(sclk) |-> low_half)
    else $error("serial clock low phase too short");
  whole_bytes_a: assert property ($rose(cs_n) |->
    (rise_cnt_q[2:0] == 3'h0 && rise_cnt_q != 6'h00))
    else $error("frame not made of whole bytes");
endmodule

/* File: spi_slave_register_port_tb_top.sv */
`timescale 1ns/1ps
module spi_slave_register_port_tb_top;
  import srp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, rx_push, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, q;
  logic        pready, pslverr;
  logic [7:0]  rx_push_data, tx_used, rx_used, m;
  logic [7:0]  bytes [3];
  logic [1:0]  speed_sel, sp;
  int          mismatches, n_compared;
  srp_if link ();
  srp_host i_srp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  srp_device i_srp_device (.pclk(pclk), .presetn(presetn), .link(link),
    .speed_sel(speed_sel), .tx_used(tx_used), .rx_used(rx_used), .rx_push(rx_push),
    .rx_push_data(rx_push_data));
  srp_chk u_chk (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .cs_n(link.cs_n),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // first byte sent ends up in the top byte of the read shift
  function automatic logic [31:0] rev(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [2:0] len,
                      input logic [31:0] d, output logic [31:0] r);
    int n;
    apb(1'b1, SRP_APB_WDATA, d, r);
    apb(1'b1, SRP_APB_CTRL, {13'h0000, len, 1'b0, a, 4'h0, sp, rd, 1'b1}, r);
    n = 0;
    do begin
      apb(1'b0, SRP_APB_STATUS, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 3000);
    chk("busy", 32'h0, {31'h0, r[0]});
    apb(1'b0, SRP_APB_RDATA, 32'h0, r);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (95000) @(posedge pclk);
    mismatches++;
    conclude();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_push = 1'b0;
    rx_push_data = 8'h00;
    seed = 32'd93;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int s = 0; s < 3; s++) begin
      sp = s[1:0];
      m = {5'h00, sp == SRP_SPEED_1M, sp};
      xfer(1'b0, SRP_ADDR_IFMODE[6:0], 3'h1, {24'h0, m}, q);
      chk("speed_sel", {30'h0, sp}, {30'h0, speed_sel});
      xfer(1'b1, SRP_ADDR_IFMODE[6:0], 3'h1, 32'h0, q);
      chk("ifmode", {24'h0, m}, {24'h0, q[7:0]});
      seed = xs(seed);
      xfer(1'b0, 7'h05, 3'h4, seed, q);
      xfer(1'b1, 7'h05, 3'h4, 32'h0, q);
      chk("scratch run", rev(seed), q);
      xfer(1'b1, 7'h07, 3'h1, 32'h0, q);
      chk("scratch byte", {24'h0, seed[23:16]}, {24'h0, q[7:0]});
      $display("test speed %0d done", s);
    end
    xfer(1'b0, SRP_ADDR_BSIZE[6:0], 3'h1, 32'h0, q);
    xfer(1'b1, SRP_ADDR_BSIZE[6:0], 3'h1, 32'h0, q);
    chk("block size", {28'h0, SRP_BSIZE_MIN}, {24'h0, q[7:0]});
    seed = xs(seed);
    xfer(1'b0, SRP_ADDR_BUFPORT[6:0], 3'h3, seed, q);
    chk("tx_used one", 32'h1, {24'h0, tx_used});
    xfer(1'b0, SRP_ADDR_BUFPORT[6:0], 3'h1, seed, q);
    chk("tx_used two", 32'h2, {24'h0, tx_used});
    xfer(1'b1, SRP_ADDR_TXUSED[6:0], 3'h1, 32'h0, q);
    chk("tx_used reg", 32'h2, {24'h0, q[7:0]});
    $display("test tx buffer done");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      bytes[i] = seed[7:0];
      rx_push <= 1'b1;
      rx_push_data <= seed[7:0];
      @(posedge pclk);
      rx_push <= 1'b0;
      @(posedge pclk);
    end
    chk("rx_used one", 32'h1, {24'h0, rx_used});
    xfer(1'b1, SRP_ADDR_BUFPORT[6:0], 3'h2, 32'h0, q);
    chk("rx data", {16'h0, bytes[0], bytes[1]}, {16'h0, q[15:0]});
    chk("rx_used zero", 32'h0, {24'h0, rx_used});
    $display("test rx buffer done");
    apb(1'b0, 12'h010, 32'h0, q);
    chk("unmapped error", 32'h1, {31'h0, perr});
    $display("test apb map done");
    conclude();
  end
endmodule
